// File: core/dcd_top.sv
// direct command decoder: turns single command bytes into action strobes
// assumes the host interface hands over whole bytes with a valid pulse
// on the same clock; the rx enable and transparent flags are levels
module dcd_top (
  input wire logic clock_i,             // 100 MHz clock
  input wire logic rst_b_i,             // async reset, active low
  input wire logic [7:0] cmd_code_i,    // command byte from host interface
  input wire logic cmd_valid_i,         // one-cycle byte strobe
  output dcd_pkg::dcd_act_t act_o,      // one-cycle action strobes
  output logic rx_enabled_o,            // receivers and decoders running
  output logic transparent_o,           // transparent mode level
  output logic nrt_running_o,           // no-response timer running
  output logic bad_cmd_o                // one-cycle unknown code pulse
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  dcd_pkg::dcd_act_t dec_act;
  logic dec_known;

  // each byte is a whole command, decoded on its own
  dcd_decode u_decode (
    .code_i(cmd_code_i),
    .valid_i(cmd_valid_i),
    .act_o(dec_act),
    .known_o(dec_known)
  );

  // ----------------------------------------------------------------
  // registered strobes
  // ----------------------------------------------------------------
  // one cycle after the byte, the matching strobe fires for one cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_o <= dcd_pkg::ACT_NONE;
      bad_cmd_o <= 1'b0;
    end else begin
      act_o <= dec_act;
      bad_cmd_o <= cmd_valid_i & ~dec_known;
    end
  end

  // ----------------------------------------------------------------
  // receiver enable level
  // ----------------------------------------------------------------
  // receivers start enabled after reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_enabled_o <= 1'b1;
    end else if (dec_act.rx_stop) begin
      rx_enabled_o <= 1'b0;
    end else if (dec_act.rx_start) begin
      rx_enabled_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transparent mode level
  // ----------------------------------------------------------------
  // only reset leaves transparent mode
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      transparent_o <= 1'b0;
    end else if (dec_act.transparent) begin
      transparent_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // no-response timer run level
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nrt_running_o <= 1'b0;
    end else if (dec_act.nrt_start) begin
      nrt_running_o <= 1'b1;
    end else if (dec_act.nrt_stop) begin
      nrt_running_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_code(logic [7:0] c);
    cmd_valid_i && cmd_code_i == c;
  endsequence

  property p_gain;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_GAIN_RESET) |=> act_o.gain_reset;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain reset strobe missing");

  property p_reg;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_REG_ADJUST) ##1 !cmd_valid_i
      |-> act_o.reg_adjust ##1 !act_o.reg_adjust;
  endproperty
  a_reg: assert property (p_reg)
    else $error("regulator strobe wrong");

  property p_cal;
    @(posedge clock_i) disable iff (!rst_b_i)
    act_o.drv_cal |-> $past(cmd_valid_i)
      && $past(cmd_code_i) == dcd_pkg::CMD_DRV_CAL;
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration strobe without command");

  property p_ampl;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_MEAS_AMPL) |=> act_o.meas_ampl && !act_o.meas_phase;
  endproperty
  a_ampl: assert property (p_ampl)
    else $error("amplitude strobe wrong");

  property p_phase;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_MEAS_PHASE) |=> act_o.meas_phase && !act_o.meas_ampl;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase strobe wrong");

  property p_rssi;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_RSSI_CLEAR) |=> act_o.rssi_clear;
  endproperty
  a_rssi: assert property (p_rssi)
    else $error("rssi clear strobe missing");

  property p_fifo;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_FIFO_CLEAR) |=> act_o.fifo_clear;
  endproperty
  a_fifo: assert property (p_fifo)
    else $error("fifo clear strobe missing");

  property p_transp;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_TRANSPARENT) |=> transparent_o;
  endproperty
  a_transp: assert property (p_transp)
    else $error("transparent mode not entered");

  property p_gp;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_GP_TIMER) |=> act_o.gp_timer;
  endproperty
  a_gp: assert property (p_gp)
    else $error("general timer strobe missing");

  property p_mask;
    @(posedge clock_i) disable iff (!rst_b_i)
    act_o.mask_rx_timer == act_o.squelch_start;
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask timer and squelch apart");

  property p_nrt;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_NRT_START) |=> nrt_running_o;
  endproperty
  a_nrt: assert property (p_nrt)
    else $error("no-response timer not running");

  property p_nrt_stop;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_NRT_STOP) |=> act_o.nrt_stop && !nrt_running_o;
  endproperty
  a_nrt_stop: assert property (p_nrt_stop)
    else $error("no-response timer not stopped");

  property p_rx;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_RX_STOP) |=> !rx_enabled_o;
  endproperty
  a_rx: assert property (p_rx)
    else $error("receivers not stopped");

  // the restart strobe and the level move on the same edge
  property p_rx_start;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_RX_START) |=> act_o.rx_start && rx_enabled_o;
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("receivers not restarted");

  // both halves of the squelch command fire from the one byte
  property p_squelch;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_code(dcd_pkg::CMD_MASK_RX_TIMER)
      |=> act_o.mask_rx_timer && act_o.squelch_start;
  endproperty
  a_squelch: assert property (p_squelch)
    else $error("mask timer or squelch strobe missing");

  // an unknown code pulse never comes with an action
  property p_bad;
    @(posedge clock_i) disable iff (!rst_b_i)
    bad_cmd_o |-> act_o == dcd_pkg::ACT_NONE && $past(cmd_valid_i);
  endproperty
  a_bad: assert property (p_bad)
    else $error("unknown code pulse with action or no byte");

  property p_one;
    @(posedge clock_i) disable iff (!rst_b_i)
    $onehot0({act_o.rx_stop, act_o.rx_start, act_o.meas_ampl,
      act_o.gain_reset, act_o.reg_adjust, act_o.drv_cal,
      act_o.meas_phase, act_o.rssi_clear, act_o.fifo_clear,
      act_o.transparent, act_o.gp_timer, act_o.mask_rx_timer,
      act_o.nrt_start, act_o.nrt_stop});
  endproperty
  a_one: assert property (p_one)
    else $error("more than one action at once");

endmodule

// File: core/dcd_pkg.sv
// package for the direct command decoder: command codes, action strobes
// assumes a single 100 MHz clock domain; imported nowhere, always scoped
package dcd_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RX_STOP = 8'hd0;
  localparam logic [7:0] CMD_RX_START = 8'hd1;
  localparam logic [7:0] CMD_MEAS_AMPL = 8'hd3;
  localparam logic [7:0] CMD_GAIN_RESET = 8'hd5;
  localparam logic [7:0] CMD_REG_ADJUST = 8'hd6;
  localparam logic [7:0] CMD_DRV_CAL = 8'hd8;
  localparam logic [7:0] CMD_MEAS_PHASE = 8'hd9;
  localparam logic [7:0] CMD_RSSI_CLEAR = 8'hda;
  localparam logic [7:0] CMD_FIFO_CLEAR = 8'hdb;
  localparam logic [7:0] CMD_TRANSPARENT = 8'hdc;
  localparam logic [7:0] CMD_GP_TIMER = 8'he0;
  localparam logic [7:0] CMD_MASK_RX_TIMER = 8'he2;
  localparam logic [7:0] CMD_NRT_START = 8'he3;
  localparam logic [7:0] CMD_NRT_STOP = 8'he8;

  // ----------------------------------------------------------------
  // one-cycle action strobes toward the front-end
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_stop;
    logic rx_start;
    logic meas_ampl;
    logic gain_reset;
    logic reg_adjust;
    logic drv_cal;
    logic meas_phase;
    logic rssi_clear;
    logic fifo_clear;
    logic transparent;
    logic gp_timer;
    logic mask_rx_timer;
    logic squelch_start;
    logic nrt_start;
    logic nrt_stop;
  } dcd_act_t;

  localparam dcd_act_t ACT_NONE = '0;

endpackage

// File: core/dcd_decode.sv
// code to action table for the direct command decoder
// assumes a valid-qualified byte from the main decoder, same clock
module dcd_decode (
  input wire logic [7:0] code_i,        // command byte
  input wire logic valid_i,             // byte present this cycle
  output dcd_pkg::dcd_act_t act_o,      // decoded strobes
  output logic known_o                  // code is a supported command
);

  // ----------------------------------------------------------------
  // table lookup
  // ----------------------------------------------------------------
  // one strobe per known code, two for the squelch code; unknown codes yield nothing
  always_comb begin
    act_o = dcd_pkg::ACT_NONE;
    known_o = 1'b1;
    case (code_i)
      dcd_pkg::CMD_RX_STOP: act_o.rx_stop = 1'b1;
      dcd_pkg::CMD_RX_START: act_o.rx_start = 1'b1;
      dcd_pkg::CMD_MEAS_AMPL: act_o.meas_ampl = 1'b1;
      dcd_pkg::CMD_GAIN_RESET: act_o.gain_reset = 1'b1;
      dcd_pkg::CMD_REG_ADJUST: act_o.reg_adjust = 1'b1;
      dcd_pkg::CMD_DRV_CAL: act_o.drv_cal = 1'b1;
      dcd_pkg::CMD_MEAS_PHASE: act_o.meas_phase = 1'b1;
      dcd_pkg::CMD_RSSI_CLEAR: act_o.rssi_clear = 1'b1;
      dcd_pkg::CMD_FIFO_CLEAR: act_o.fifo_clear = 1'b1;
      dcd_pkg::CMD_TRANSPARENT: act_o.transparent = 1'b1;
      dcd_pkg::CMD_GP_TIMER: act_o.gp_timer = 1'b1;
      dcd_pkg::CMD_MASK_RX_TIMER: begin
        act_o.mask_rx_timer = 1'b1;
        act_o.squelch_start = 1'b1;
      end
      dcd_pkg::CMD_NRT_START: act_o.nrt_start = 1'b1;
      dcd_pkg::CMD_NRT_STOP: act_o.nrt_stop = 1'b1;
      default: known_o = 1'b0;
    endcase
    if (!valid_i) begin
      act_o = dcd_pkg::ACT_NONE;
      known_o = 1'b0;
    end
  end

endmodule

// File: tb/dcd_host_model.sv
// host side model: hands the decoder one command byte per request
// assumes the decoder samples its byte on the rising edge of clock_i
module dcd_host_model (
  input wire logic clock_i,       // decoder clock
  output logic [7:0] cmd_code_o,  // command byte
  output logic cmd_valid_o        // one-cycle byte strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle lines at time zero
  initial begin
    cmd_code_o = 8'h00;
    cmd_valid_o = 1'b0;
  end

  // ------------------------------------------------------------------
  // request tasks, driven just after the rising edge
  // ------------------------------------------------------------------
  // a whole byte in one cycle, no operand after it
  task automatic issue(input logic [7:0] code);
    @(posedge clock_i);
    #1;
    cmd_code_o = code;
    cmd_valid_o = 1'b1;
  endtask

  // release: the code line shows the inverse; a second release in a row brings the stale byte back
  task automatic idle();
    @(posedge clock_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_code_o = ~cmd_code_o;
  endtask
endmodule

// File: tb/direct_command_decoder_tb.sv
// self-checking bench for the direct command decoder
// assumes dcd_pkg, dcd_top and dcd_host_model are compiled before it
module direct_command_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // stimulus table: code, expected strobes, expected unknown pulse
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] code;
    logic [14:0] act;
    logic bad;
  } dcd_row_t;

  localparam int NROWS = 18;
  localparam dcd_row_t ROWS [NROWS] = '{
    '{8'hd0, 15'h4000, 1'b0},
    '{8'hd1, 15'h2000, 1'b0},
    '{8'hd3, 15'h1000, 1'b0},
    '{8'hd5, 15'h0800, 1'b0},
    '{8'hd6, 15'h0400, 1'b0},
    '{8'hd8, 15'h0200, 1'b0},
    '{8'hd9, 15'h0100, 1'b0},
    '{8'hda, 15'h0080, 1'b0},
    '{8'hdb, 15'h0040, 1'b0},
    '{8'hdc, 15'h0020, 1'b0},
    '{8'he0, 15'h0010, 1'b0},
    '{8'he2, 15'h000c, 1'b0},
    '{8'he3, 15'h0002, 1'b0},
    '{8'he8, 15'h0001, 1'b0},
    '{8'hd2, 15'h0000, 1'b1},
    '{8'hdf, 15'h0000, 1'b1},
    '{8'he1, 15'h0000, 1'b1},
    '{8'he4, 15'h0000, 1'b1}
  };
  localparam int MAX_CYCLES = 2000;

  logic clock_i;
  logic rst_b_i;
  wire logic [7:0] cmd_code;
  wire logic cmd_valid;
  wire dcd_pkg::dcd_act_t act;
  wire logic rx_en;
  wire logic transp;
  wire logic nrt_run;
  wire logic bad_cmd;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  // ------------------------------------------------------------------
  // design, host model, clock and hang guard
  // ------------------------------------------------------------------
  dcd_top dcd_top_i (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .cmd_code_i(cmd_code),
    .cmd_valid_i(cmd_valid),
    .act_o(act),
    .rx_enabled_o(rx_en),
    .transparent_o(transp),
    .nrt_running_o(nrt_run),
    .bad_cmd_o(bad_cmd)
  );

  dcd_host_model dcd_host_model_i (
    .clock_i(clock_i),
    .cmd_code_o(cmd_code),
    .cmd_valid_o(cmd_valid)
  );

  // free-running 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // cut a hang short after a fixed number of cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      failures++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------------
  // compare and closing tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0;
    repeat (20) @(posedge clock_i);
    #1;
    chk({act, bad_cmd}, 16'h0000);
    chk({13'h0, rx_en, transp, nrt_run}, 16'h0004);
    rst_b_i = 1'b1;
    // table rows, each answered one cycle after it is taken
    foreach (ROWS[i]) begin
      dcd_host_model_i.issue(ROWS[i].code);
      dcd_host_model_i.idle();
      chk({act, bad_cmd}, {ROWS[i].act, ROWS[i].bad});
    end
    // strobes last one cycle only
    dcd_host_model_i.idle();
    chk({act, bad_cmd}, 16'h0000);
    chk({15'h0, transp}, 16'h0001);
    // back to back start then stop of the no-response timer
    dcd_host_model_i.issue(8'he3);
    dcd_host_model_i.issue(8'he8);
    chk({act, nrt_run}, {15'h0002, 1'b1});
    dcd_host_model_i.idle();
    chk({act, nrt_run}, {15'h0001, 1'b0});
    // back to back receiver stop then start
    dcd_host_model_i.issue(8'hd0);
    dcd_host_model_i.issue(8'hd1);
    chk({act, rx_en}, {15'h4000, 1'b0});
    dcd_host_model_i.idle();
    chk({act, rx_en}, {15'h2000, 1'b1});
    // squelch pair followed at once by an unknown code
    dcd_host_model_i.issue(8'he2);
    dcd_host_model_i.issue(8'he4);
    chk({act, bad_cmd}, {15'h000c, 1'b0});
    dcd_host_model_i.idle();
    chk({act, bad_cmd}, {15'h0000, 1'b1});
    // mid-run reset with levels moved away from their reset values
    dcd_host_model_i.issue(8'he3);
    dcd_host_model_i.issue(8'hd0);
    dcd_host_model_i.idle();
    chk({13'h0, rx_en, transp, nrt_run}, 16'h0003);
    rst_b_i = 1'b0;
    #1;
    chk({13'h0, rx_en, transp, nrt_run}, 16'h0004);
    repeat (2) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    dcd_host_model_i.issue(8'hdc);
    dcd_host_model_i.idle();
    chk({act, transp}, {15'h0020, 1'b1});
    give_verdict();
  end
endmodule
